// [verilog/sadc_pkg.sv]
package sadc_pkg;

  // System clock period in nanoseconds (50 MHz).
  localparam int CLK_PERIOD_NS = 20;

  // Result word width.
  localparam int WORD_BITS = 12;

  // Reset value of result and shift registers.
  localparam logic [11:0] CODE_RESET = 12'h000;

  // Typical conversion time; busy is low for this long.
  localparam int CONVERT_STROBE_N_TIME_NS = 12000;
  localparam int CONVERT_STROBE_N_CYCLES  = CONVERT_STROBE_N_TIME_NS / CLK_PERIOD_NS;

  // Start of conversion to first internal rising clock edge.
  localparam int FIRST_EDGE_NS     = 2000;
  localparam int FIRST_EDGE_CYCLES = FIRST_EDGE_NS / CLK_PERIOD_NS;

  // Quarter of the internal shift clock period; also data setup and hold.
  localparam int QUARTER_NS     = 180;
  localparam int QUARTER_CYCLES = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Window before busy rises in which the external clock must stay low.
  localparam int GUARD_NS     = 5000;
  localparam int GUARD_CYCLES = GUARD_NS / CLK_PERIOD_NS;

  // Least spacing between two conversion starts.
  localparam int START_GAP_NS     = 25000;
  localparam int START_GAP_CYCLES = (START_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Width of the host's convert strobe pulse.
  localparam int CONVERT_STROBE_N_PULSE_NS     = 100;
  localparam int CONVERT_STROBE_N_PULSE_CYCLES = (CONVERT_STROBE_N_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Half period of the host-made external shift clock.
  localparam int EXT_HALF_NS     = 160;
  localparam int EXT_HALF_CYCLES = (EXT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Counter width wide enough for every count above.
  localparam int CNT_W = 11;

  // Device conversion states.
  typedef enum logic [1:0] {
    SADC_IDLE = 2'b01,
    SADC_CONVERT_STROBE_N = 2'b10
  } sadc_dev_state_t;

  // Host sequencing states.
  typedef enum logic [3:0] {
    SADC_H_IDLE  = 4'b0001,
    SADC_H_PULSE = 4'b0010,
    SADC_H_WAIT  = 4'b0100,
    SADC_H_READ  = 4'b1000
  } sadc_host_state_t;

endpackage

// [verilog/sadc_if.sv]
`timescale 1ns/1ps
// Pins between converter and host; the three-state wires are resolved here.
interface sadc_if;
  logic convert_strobe_n;    // Host to device, falling edge starts conversion.
  logic chip_select_n;       // Host to device, low enables device outputs.
  logic clock_source_select; // Host to device, high means host makes the clock.
  logic dev_sclk_o;          // Device drive value for the shift clock.
  logic dev_sclk_oe;         // Device drives the shift clock while high.
  logic host_sclk_o;         // Host drive value for the shift clock.
  logic host_sclk_oe;        // Host drives the shift clock while high.
  logic serial_shift_clock;  // Resolved shift clock wire.
  logic data_o;              // Device drive value for serial data.
  logic data_oe;             // Device drives serial data while high.
  logic serial_data;         // Resolved serial data wire.
  logic busy_o;              // Device drive value for busy, low while converting.
  logic busy_oe;             // Device drives busy while high.
  logic busy_n;              // Resolved busy wire.

  // Undriven clock and data read low, undriven busy reads high (pulled up).
  assign serial_shift_clock = dev_sclk_oe ? dev_sclk_o : (host_sclk_oe & host_sclk_o);
  assign serial_data        = data_oe & data_o;
  assign busy_n             = busy_oe ? busy_o : 1'b1;

  modport device (
    input  convert_strobe_n,
    input  chip_select_n,
    input  clock_source_select,
    input  serial_shift_clock,
    output dev_sclk_o,
    output dev_sclk_oe,
    output data_o,
    output data_oe,
    output busy_o,
    output busy_oe
  );

  modport host (
    output convert_strobe_n,
    output chip_select_n,
    output clock_source_select,
    output host_sclk_o,
    output host_sclk_oe,
    input  serial_shift_clock,
    input  serial_data,
    input  busy_n
  );
endinterface

// [verilog/sadc_device.sv]
`timescale 1ns/1ps
// Converter end: conversion timing, busy, internal and external serial readout.
module sadc_device (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  sadc_if.device           link,
  input  wire logic [11:0] sample_code,
  output logic             sample_hold,
  output logic             result_strobe,
  output logic [11:0]      result_word
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [1:0] convert_strobe_n_sync;  // Convert strobe, two flops.
  logic [1:0] cs_sync;    // Chip select, two flops.
  logic [1:0] sel_sync;   // Clock source select, two flops.
  logic [1:0] sclk_sync;  // External shift clock, two flops.
  logic       convert_strobe_n_last;  // Previous synchronised strobe, for edge detect.
  logic       sclk_last;  // Previous synchronised shift clock.

  // Every pin passes two flops; only the second stage is read below.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      convert_strobe_n_sync <= 2'b11;
      cs_sync   <= 2'b11;
      sel_sync  <= 2'b00;
      sclk_sync <= 2'b00;
      convert_strobe_n_last <= 1'b1;
      sclk_last <= 1'b0;
    end else begin
      convert_strobe_n_sync <= {convert_strobe_n_sync[0], link.convert_strobe_n};
      cs_sync   <= {cs_sync[0], link.chip_select_n};
      sel_sync  <= {sel_sync[0], link.clock_source_select};
      sclk_sync <= {sclk_sync[0], link.serial_shift_clock};
      convert_strobe_n_last <= convert_strobe_n_sync[1];
      sclk_last <= sclk_sync[1];
    end
  end

  logic convert_strobe_n_fall;  // Falling strobe edge seen this cycle.
  logic cs_n;       // Synchronised chip select.
  logic ext_mode;   // Host supplies the shift clock.
  logic ext_rise;   // Gated rising edge of the host shift clock.

  assign convert_strobe_n_fall = convert_strobe_n_last & ~convert_strobe_n_sync[1];
  assign cs_n      = cs_sync[1];
  assign ext_mode  = sel_sync[1];
  // Chip select gates the host clock, so a deselected device never shifts on it.
  assign ext_rise  = ext_mode & ~cs_n & sclk_sync[1] & ~sclk_last;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing.

  sadc_pkg::sadc_dev_state_t state;  // Idle or converting.
  logic [sadc_pkg::CNT_W-1:0] convert_strobe_n_cnt;  // Cycles since conversion start.
  logic start;     // Conversion begins this cycle.
  logic load_tick; // Cycle before the final conversion cycle, two cycles before busy rises.
  logic last_tick; // Final cycle of the conversion.

  // The strobe is looked at only while idle; chip select plays no part.
  assign start     = (state == sadc_pkg::SADC_IDLE) & convert_strobe_n_fall;
  assign load_tick = (state == sadc_pkg::SADC_CONVERT_STROBE_N) &
                     (convert_strobe_n_cnt == sadc_pkg::CNT_W'(sadc_pkg::CONVERT_STROBE_N_CYCLES - 2));
  assign last_tick = (state == sadc_pkg::SADC_CONVERT_STROBE_N) &
                     (convert_strobe_n_cnt == sadc_pkg::CNT_W'(sadc_pkg::CONVERT_STROBE_N_CYCLES - 1));

  // State register; edges arriving mid-conversion fall through unnoticed.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state <= sadc_pkg::SADC_IDLE;
    end else begin
      case (state)
        sadc_pkg::SADC_IDLE: begin
          if (convert_strobe_n_fall) begin
            state <= sadc_pkg::SADC_CONVERT_STROBE_N;
          end
        end
        sadc_pkg::SADC_CONVERT_STROBE_N: begin
          if (last_tick) begin
            state <= sadc_pkg::SADC_IDLE;
          end
        end
        default: begin
          state <= sadc_pkg::SADC_IDLE;
        end
      endcase
    end
  end

  // Cycle counter for the conversion; it restarts at each start.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      convert_strobe_n_cnt <= '0;
    end else if (start) begin
      convert_strobe_n_cnt <= '0;
    end else if (state == sadc_pkg::SADC_CONVERT_STROBE_N) begin
      convert_strobe_n_cnt <= convert_strobe_n_cnt + 1'b1;
    end
  end

  // Busy falls with the start and rises after the last conversion cycle.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      link.busy_o <= 1'b1;
    end else if (start) begin
      link.busy_o <= 1'b0;
    end else if (last_tick) begin
      link.busy_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working register and result hand-off.

  logic [11:0] work_reg;  // Code captured at the hold instant.
  logic        ext_spoil; // Host clock was active inside the guard window.

  // The code is stored as given, so 7FF, 000, FFF and 800 pass unchanged.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      work_reg    <= sadc_pkg::CODE_RESET;
      sample_hold <= 1'b0;
    end else begin
      sample_hold <= start;
      if (start) begin
        work_reg <= sample_code;
      end
    end
  end

  // A clock seen high with the device selected late in conversion spoils the update.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ext_spoil <= 1'b0;
    end else if (start) begin
      ext_spoil <= 1'b0;
    end else if ((state == sadc_pkg::SADC_CONVERT_STROBE_N) & ext_mode & ~cs_n & sclk_sync[1] &
                 (convert_strobe_n_cnt >= sadc_pkg::CNT_W'(sadc_pkg::CONVERT_STROBE_N_CYCLES - sadc_pkg::GUARD_CYCLES))) begin
      ext_spoil <= 1'b1;
    end
  end

  // The finished code becomes the last completed result just before busy rises.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      result_word   <= sadc_pkg::CODE_RESET;
      result_strobe <= 1'b0;
    end else begin
      result_strobe <= load_tick;
      if (load_tick) begin
        result_word <= work_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal clock transmitter timing.

  logic       tx_on;    // Internal transmission running.
  logic [3:0] q_cnt;    // Cycles within one quarter period.
  logic [1:0] phase;    // Quarter within the bit period.
  logic [3:0] bit_cnt;  // Bits already sent.
  logic       q_tick;   // End of a quarter.
  logic       tx_begin; // First data bit goes out now.
  logic       bit_next; // Next bit is presented in the low phase.

  assign q_tick   = tx_on & (q_cnt == 4'(sadc_pkg::QUARTER_CYCLES - 1));
  // First data one quarter ahead of the first rising edge at 2 us.
  assign tx_begin = ~ext_mode & (state == sadc_pkg::SADC_CONVERT_STROBE_N) &
                    (convert_strobe_n_cnt == sadc_pkg::CNT_W'(sadc_pkg::FIRST_EDGE_CYCLES -
                                                  sadc_pkg::QUARTER_CYCLES));
  assign bit_next = q_tick & (phase == 2'd3) & (bit_cnt != 4'(sadc_pkg::WORD_BITS - 1));

  // Quarter sequencer: data set, rise, hold, fall; twelve rounds and then stop.
  // Changing data only mid-low keeps it clean around both clock edges.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_on       <= 1'b0;
      q_cnt       <= '0;
      phase       <= 2'd0;
      bit_cnt     <= '0;
      link.dev_sclk_o <= 1'b0;
    end else if (tx_begin) begin
      tx_on   <= 1'b1;
      q_cnt   <= '0;
      phase   <= 2'd0;
      bit_cnt <= '0;
    end else if (tx_on) begin
      q_cnt <= q_tick ? 4'd0 : q_cnt + 1'b1;
      if (q_tick) begin
        phase <= phase + 1'b1;
        if (phase == 2'd0) begin
          link.dev_sclk_o <= 1'b1;
        end else if (phase == 2'd2) begin
          link.dev_sclk_o <= 1'b0;
        end else if (phase == 2'd3) begin
          if (bit_cnt == 4'(sadc_pkg::WORD_BITS - 1)) begin
            tx_on <= 1'b0;
          end else begin
            bit_cnt <= bit_cnt + 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output shift register shared by both clock modes.

  logic [11:0] shift_reg; // Word being sent, MSB at the top.
  logic        tx_end;    // Last internal bit period finishes.

  assign tx_end = q_tick & (phase == 2'd3) & (bit_cnt == 4'(sadc_pkg::WORD_BITS - 1));

  // Internal mode reloads the previous result at each start; external mode
  // reloads the new one before busy rises unless the host clock spoiled it.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      shift_reg   <= sadc_pkg::CODE_RESET;
      link.data_o <= 1'b0;
    end else if (start & ~ext_mode) begin
      shift_reg <= result_word;
    end else if (tx_begin) begin
      link.data_o <= shift_reg[11];
      shift_reg   <= {shift_reg[10:0], 1'b0};
    end else if (bit_next) begin
      link.data_o <= shift_reg[11];
      shift_reg   <= {shift_reg[10:0], 1'b0};
    end else if (tx_end) begin
      link.data_o <= 1'b0;
    end else if (load_tick & ext_mode & ~ext_spoil) begin
      shift_reg   <= work_reg;
      link.data_o <= 1'b0;
    end else if (ext_rise) begin
      link.data_o <= shift_reg[11];
      shift_reg   <= {shift_reg[10:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output enables.

  // Deselected outputs float; the shift clock pin is driven only in internal mode.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      link.data_oe     <= 1'b0;
      link.busy_oe     <= 1'b0;
      link.dev_sclk_oe <= 1'b0;
    end else begin
      link.data_oe     <= ~cs_n;
      link.busy_oe     <= ~cs_n;
      link.dev_sclk_oe <= ~cs_n & ~ext_mode;
    end
  end

endmodule

// [verilog/sadc_host.sv]
`timescale 1ns/1ps
// Host end: paces conversions, makes the strobe and collects the results.
module sadc_host (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  sadc_if.host             link,
  input  wire logic        start_req,
  input  wire logic        ext_clock_mode,
  output logic             start_ready,
  output logic             result_strobe,
  output logic [11:0]      result_word
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [1:0] busy_sync;  // Busy, two flops.
  logic [1:0] data_sync;  // Serial data, two flops.
  logic [1:0] sclk_sync;  // Shift clock, two flops.
  logic       sclk_last;  // Previous synchronised shift clock.

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      busy_sync <= 2'b11;
      data_sync <= 2'b00;
      sclk_sync <= 2'b00;
      sclk_last <= 1'b0;
    end else begin
      busy_sync <= {busy_sync[0], link.busy_n};
      data_sync <= {data_sync[0], link.serial_data};
      sclk_sync <= {sclk_sync[0], link.serial_shift_clock};
      sclk_last <= sclk_sync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  sadc_pkg::sadc_host_state_t state;  // Host sequence state.
  logic [sadc_pkg::CNT_W-1:0] gap_cnt;  // Cycles left before another start.
  logic [3:0]  hcnt;      // Pulse or half-period counter.
  logic [3:0]  bits;      // Bits gathered.
  logic [11:0] gather;    // Incoming bits, MSB first.
  logic        seen_low;  // Busy has been seen low in this conversion.
  logic        mode;      // Mode latched at the start.
  logic        take;      // Start request taken.

  assign take = start_req & start_ready;

  // Ready only when idle and the 25 us spacing has run out.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      gap_cnt     <= '0;
      start_ready <= 1'b0;
    end else begin
      if (take) begin
        gap_cnt <= sadc_pkg::CNT_W'(sadc_pkg::START_GAP_CYCLES - 1);
      end else if (gap_cnt != '0) begin
        gap_cnt <= gap_cnt - 1'b1;
      end
      start_ready <= ~take & (state == sadc_pkg::SADC_H_IDLE) &
                     (gap_cnt <= sadc_pkg::CNT_W'(1));
    end
  end

  // Main sequence: strobe pulse, wait for busy, then read if the host clocks.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state                    <= sadc_pkg::SADC_H_IDLE;
      hcnt                     <= '0;
      bits                     <= '0;
      gather                   <= sadc_pkg::CODE_RESET;
      seen_low                 <= 1'b0;
      mode                     <= 1'b0;
      result_word              <= sadc_pkg::CODE_RESET;
      result_strobe            <= 1'b0;
      link.convert_strobe_n    <= 1'b1;
      link.chip_select_n       <= 1'b1;
      link.clock_source_select <= 1'b0;
      link.host_sclk_o         <= 1'b0;
      link.host_sclk_oe        <= 1'b0;
    end else begin
      result_strobe            <= 1'b0;
      link.chip_select_n       <= 1'b0;
      link.host_sclk_oe        <= mode;
      case (state)
        sadc_pkg::SADC_H_IDLE: begin
          // Strobe stays high between conversions, far beyond 15 ns.
          link.clock_source_select <= ext_clock_mode;
          if (take) begin
            mode                  <= ext_clock_mode;
            link.convert_strobe_n <= 1'b0;
            hcnt                  <= '0;
            bits                  <= '0;
            seen_low              <= 1'b0;
            state                 <= sadc_pkg::SADC_H_PULSE;
          end
        end
        sadc_pkg::SADC_H_PULSE: begin
          // Short low pulse, then the strobe stays still for the conversion.
          hcnt <= hcnt + 1'b1;
          if (hcnt == 4'(sadc_pkg::CONVERT_STROBE_N_PULSE_CYCLES - 1)) begin
            link.convert_strobe_n <= 1'b1;
            state                 <= sadc_pkg::SADC_H_WAIT;
          end
        end
        sadc_pkg::SADC_H_WAIT: begin
          if (~busy_sync[1]) begin
            seen_low <= 1'b1;
          end
          // Internal mode: take a bit at each rising device clock.
          if (~mode & sclk_sync[1] & ~sclk_last) begin
            gather <= {gather[10:0], data_sync[1]};
          end
          if (seen_low & busy_sync[1]) begin
            hcnt <= '0;
            if (mode) begin
              state <= sadc_pkg::SADC_H_READ;
            end else begin
              result_word   <= gather;
              result_strobe <= 1'b1;
              state         <= sadc_pkg::SADC_H_IDLE;
            end
          end
        end
        sadc_pkg::SADC_H_READ: begin
          // Clock only after busy rose, so it is low through the guard window.
          hcnt <= hcnt + 1'b1;
          if (hcnt == 4'(sadc_pkg::EXT_HALF_CYCLES - 1)) begin
            hcnt <= '0;
            if (~link.host_sclk_o) begin
              if (bits == 4'(sadc_pkg::WORD_BITS)) begin
                result_word   <= gather;
                result_strobe <= 1'b1;
                state         <= sadc_pkg::SADC_H_IDLE;
              end else begin
                link.host_sclk_o <= 1'b1;
              end
            end else begin
              // Sample late in the high phase, then drop the clock.
              gather           <= {gather[10:0], data_sync[1]};
              bits             <= bits + 1'b1;
              link.host_sclk_o <= 1'b0;
            end
          end
        end
        default: begin
          state <= sadc_pkg::SADC_H_IDLE;
        end
      endcase
    end
  end

endmodule

// [tb/sadc_link_props.sv]
`timescale 1ns/1ps
// Pin checker beside the link; the device reset gates every check.
module sadc_link_props (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic convert_strobe_n,
  input wire logic chip_select_n,
  input wire logic clock_source_select,
  input wire logic dev_sclk_o,
  input wire logic dev_sclk_oe,
  input wire logic data_o,
  input wire logic data_oe,
  input wire logic busy_o,
  input wire logic busy_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [10:0] low_cnt;  // Cycles busy has been driven low.
  logic [10:0] gap_cnt;  // Cycles since the last internal clock rise.
  logic [4:0]  rise_cnt; // Internal clock rises in this conversion.
  logic        sclk_q;   // Clock one cycle back.
  logic        busy_q;   // Busy one cycle back.
  ////////////////////////////////////////////////////////////////////////////
  // Counters are kept here since repetitions cannot reach these lengths.
  always_ff @(posedge sys_clk) begin
    sclk_q   <= rst_b & dev_sclk_o;
    busy_q   <= ~rst_b | busy_o;
    low_cnt  <= (!rst_b || busy_o) ? 11'h000 : low_cnt + 11'h001;
    gap_cnt  <= (dev_sclk_o && !sclk_q) ? 11'h001 : gap_cnt + {10'h000, gap_cnt != 11'h7FF};
    rise_cnt <= (!rst_b || (busy_q && !busy_o)) ? 5'h00 : rise_cnt + {4'h0, dev_sclk_o && !sclk_q};
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    $fell(convert_strobe_n) && busy_o;
  endsequence
  sequence s_int_convert_strobe_n;
    $fell(busy_o) && !clock_source_select;
  endsequence
  a_busy_prompt: assert property (s_start |-> ##4 !busy_o)
    else $error("busy did not fall after the strobe");
  a_busy_length: assert property ($rose(busy_o) |-> low_cnt == sadc_pkg::CONVERT_STROBE_N_CYCLES)
    else $error("busy low time is wrong");
  a_no_restart: assert property ($rose(busy_o) |-> busy_o[*5])
    else $error("conversion restarted at once");
  a_first_edge: assert property (s_int_convert_strobe_n |-> ##[94:102] $rose(dev_sclk_o))
    else $error("first internal clock edge late or early");
  a_clock_period: assert property ($rose(dev_sclk_o) && rise_cnt != 5'h00
      |-> gap_cnt >= 11'h01E && gap_cnt <= 11'h02A)
    else $error("internal clock period out of range");
  a_twelve_pulses: assert property ($rose(busy_o) && !clock_source_select |-> rise_cnt == 5'h0C)
    else $error("internal clock pulse count is wrong");
  a_data_stable: assert property (!clock_source_select && (dev_sclk_o || $fell(dev_sclk_o)) |-> $stable(data_o))
    else $error("data moved around an internal clock edge");
  a_idle_low: assert property (!clock_source_select && $stable(clock_source_select) && busy_o
      |-> !dev_sclk_o && !data_o)
    else $error("clock or data high while idle");
  a_busy_frames: assert property (dev_sclk_o && !clock_source_select |-> !busy_o)
    else $error("internal clock outside busy");
  a_outputs_float: assert property (chip_select_n[*5] |-> !busy_oe && !data_oe && !dev_sclk_oe)
    else $error("outputs driven with chip select high");
  a_outputs_drive: assert property ((!chip_select_n && $stable(clock_source_select))[*5]
      |-> busy_oe && data_oe && (dev_sclk_oe == !clock_source_select))
    else $error("output enables wrong with chip select low");
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
// Both link ends face each other; the host has its own reset to float the pins.
module testbench;
  logic        sys_clk, rst_b, host_rst_b, start_req, ext_clock_mode;
  logic [11:0] sample_code;  // Code the converter samples.
  logic        start_ready;  // Host accepts a request.
  logic        dev_strobe;   // Device finished a conversion.
  logic        host_strobe;  // Host collected a word.
  logic [11:0] dev_word;     // Device result.
  logic [11:0] host_word;    // Word the host read back.
  logic        dev_hold;     // Device hold pulse, one per started conversion.
  int          hold_count;   // Hold pulses seen so far; two-state, so it starts at zero.
  int          bad_count, num_checks;
  sadc_if link_if();
  sadc_device sadc_device_i (.sys_clk(sys_clk), .rst_b(rst_b), .link(link_if), .sample_code(sample_code),
    .sample_hold(dev_hold), .result_strobe(dev_strobe), .result_word(dev_word));
  sadc_host sadc_host_i (.sys_clk(sys_clk), .rst_b(host_rst_b), .link(link_if), .start_req(start_req),
    .ext_clock_mode(ext_clock_mode), .start_ready(start_ready), .result_strobe(host_strobe),
    .result_word(host_word));
  sadc_link_props sadc_link_props_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .convert_strobe_n(link_if.convert_strobe_n), .chip_select_n(link_if.chip_select_n),
    .clock_source_select(link_if.clock_source_select), .dev_sclk_o(link_if.dev_sclk_o),
    .dev_sclk_oe(link_if.dev_sclk_oe), .data_o(link_if.data_o), .data_oe(link_if.data_oe),
    .busy_o(link_if.busy_o), .busy_oe(link_if.busy_oe));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Counts hold pulses, so each request can be seen to start exactly one conversion.
  always @(posedge sys_clk) begin
    if (dev_hold === 1'b1) begin
      hold_count <= hold_count + 1;
    end
  end
  task automatic give_verdict;
    $display("Checks: %0d, mismatches: %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Bounded wait on a strobe (0 host ready, 1 device result, 2 host result); a hang ends the run.
  task automatic wait_for(input int which);
    int   n;
    logic sig;
    n   = 0;
    sig = (which == 0) ? start_ready : ((which == 1) ? dev_strobe : host_strobe);
    while (sig !== 1'b1 && n < 4000) begin
      @(posedge sys_clk);
      n++;
      sig = (which == 0) ? start_ready : ((which == 1) ? dev_strobe : host_strobe);
    end
    if (sig !== 1'b1) begin
      bad_count++;
      $display("MISMATCH at %0t: wait ran out", $time);
      give_verdict();
    end
  endtask
  // One full conversion; the host word is judged by the caller.
  task automatic convert(input logic [11:0] code);
    int base;
    base = hold_count;
    sample_code <= code;
    wait_for(0);
    start_req <= 1'b1;
    @(posedge sys_clk);
    start_req <= 1'b0;
    wait_for(1);
    check(dev_word, code, "device word");
    check(12'(hold_count - base), 12'h001, "hold pulses");
    @(posedge sys_clk);
    wait_for(2);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Internal clock: each frame carries the previous result, all table codes.
  task automatic t_internal;
    logic [11:0] codes [4];
    logic [11:0] prev;
    codes = '{12'h7FF, 12'h000, 12'hFFF, 12'h800};
    prev = sadc_pkg::CODE_RESET;
    foreach (codes[i]) begin
      convert(codes[i]);
      check(host_word, prev, "internal word");
      prev = codes[i];
    end
  endtask
  // External clock: the host reads the fresh result after busy rises.
  task automatic t_external;
    ext_clock_mode <= 1'b1;
    repeat (4) @(posedge sys_clk);
    convert(12'h5A3);
    check(host_word, 12'h5A3, "external word");
    convert(12'hA5C);
    check(host_word, 12'hA5C, "external word");
  endtask
  // Host held in reset keeps chip select high, so every output floats.
  task automatic t_float;
    host_rst_b <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check({6'h00, link_if.busy_oe, link_if.data_oe, link_if.dev_sclk_oe, link_if.busy_n, link_if.serial_data,
           link_if.serial_shift_clock}, 12'h004, "floated");
    host_rst_b <= 1'b1;
    @(posedge sys_clk);
  endtask
  initial begin
    {rst_b, host_rst_b, start_req, ext_clock_mode} = 4'h0;
    sample_code = 12'h000;
    repeat (6) @(posedge sys_clk);
    rst_b      <= 1'b1;
    host_rst_b <= 1'b1;
    t_internal();
    t_external();
    t_float();
    give_verdict();
  end
endmodule
